// *** sim/orwdt_top_tb.sv ***
// testbench: apb register access and overflow reset checks of the watchdog
module orwdt_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // short counts keep the run brief
  localparam int SYSD = 16;
  localparam int SUBD = 4;
  localparam int OSCN = 8;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic subclock = 1'b0;
  logic osc_clock = 1'b0;
  orwdt_pkg::orwdt_mode_t power_mode = '0;
  logic wdt_chip_reset;
  logic irq;
  int n_fail = 0;
  int cmp_count = 0;
  int osc_n = 0;
  logic [31:0] rd;
  logic err;
  logic [31:0] c1;

  orwdt_top #(.SYS_DIV(SYSD), .SUB_DIV(SUBD), .RESET_OSC_CYCLES(OSCN)) uut (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .subclock(subclock),
    .osc_clock(osc_clock), .power_mode(power_mode),
    .wdt_chip_reset(wdt_chip_reset), .irq(irq));

  // foreign clocks, periods unrelated to the system clock
  always #2.5 clock = ~clock;
  always #10.1 subclock = ~subclock;
  always #20.3 osc_clock = ~osc_clock;
  // oscillator edges seen while the chip reset pulse stands
  always @(posedge osc_clock) if (wdt_chip_reset === 1'b1) osc_n++;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask : rdc

  task idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle

  // bounded wait for the chip reset level
  task wait_rst(input logic lvl);
    int k;
    k = 0;
    while (wdt_chip_reset !== lvl && k < 1000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 1000) n_fail++;
  endtask : wait_rst

  task print_verdict;
    $display("counts: compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // hang guard, far beyond the several hundred cycles the tests need
  initial begin
    #50000;
    n_fail++;
    print_verdict();
  end

  // main sequence
  initial begin
    idle(8);
    reset <= 1'b0;
    rdc(orwdt_pkg::ADDR_CSR, 32'h000000AA);
    rdc(orwdt_pkg::ADDR_CNT, 32'h00000000);
    rdc(orwdt_pkg::ADDR_STOP, 32'h000000FF);
    rdc(orwdt_pkg::ADDR_PMODE, 32'h00000000);
    $display("test reset_values done");
    // refused counter write raises a masked-in interrupt
    wr(orwdt_pkg::ADDR_IRQ_MASK, 32'h00000002);
    wr(orwdt_pkg::ADDR_CNT, 32'h00000055);
    rdc(orwdt_pkg::ADDR_CNT, 32'h00000000);
    chk(irq, 1'b1);
    rdc(orwdt_pkg::ADDR_IRQ_STAT, 32'h00000002);
    wr(orwdt_pkg::ADDR_IRQ_STAT, 32'h00000002);
    idle(1);
    chk(irq, 1'b0);
    $display("test refused_write done");
    // guards: enables move only with their guard written zero
    wr(orwdt_pkg::ADDR_CSR, 32'h000000C4);
    rdc(orwdt_pkg::ADDR_CSR, 32'h000000AA);
    wr(orwdt_pkg::ADDR_CSR, 32'h00000044);
    rdc(orwdt_pkg::ADDR_CSR, 32'h000000EA);
    wr(orwdt_pkg::ADDR_CSR, 32'h00000050);
    rdc(orwdt_pkg::ADDR_CSR, 32'h000000FA);
    wr(orwdt_pkg::ADDR_CSR, 32'h00000090);
    rdc(orwdt_pkg::ADDR_CSR, 32'h000000FA);
    wr(orwdt_pkg::ADDR_CSR, 32'h0000005C);
    rdc(orwdt_pkg::ADDR_CSR, 32'h000000FA);
    wr(orwdt_pkg::ADDR_CSR, 32'h00000054);
    rdc(orwdt_pkg::ADDR_CSR, 32'h000000FE);
    $display("test guards done");
    // tick rate of the system source prescaler
    wr(orwdt_pkg::ADDR_CNT, 32'h00000000);
    idle(10 * SYSD);
    xfer(1'b0, orwdt_pkg::ADDR_CNT, 32'h00000000);
    chk(rd >= 9 && rd <= 11, 32'h1);
    $display("test tick_rate done");
    // standby request while running is stored but deferred
    wr(orwdt_pkg::ADDR_STOP, 32'h00000000);
    xfer(1'b0, orwdt_pkg::ADDR_STOP, 32'h00000000);
    chk(rd & 32'h4, 32'h0);
    xfer(1'b0, orwdt_pkg::ADDR_CNT, 32'h00000000);
    c1 = rd;
    idle(4 * SYSD);
    xfer(1'b0, orwdt_pkg::ADDR_CNT, 32'h00000000);
    chk(rd > c1, 32'h1);
    wr(orwdt_pkg::ADDR_CSR, 32'h00000050);
    rdc(orwdt_pkg::ADDR_CSR, 32'h000000FA);
    xfer(1'b0, orwdt_pkg::ADDR_CNT, 32'h00000000);
    c1 = rd;
    idle(4 * SYSD);
    rdc(orwdt_pkg::ADDR_CNT, c1);
    wr(orwdt_pkg::ADDR_STOP, 32'h000000FF);
    $display("test standby done");
    // subclock source, halt and subactive modes
    wr(orwdt_pkg::ADDR_PMODE, 32'h00000020);
    rdc(orwdt_pkg::ADDR_PMODE, 32'h00000020);
    power_mode.halt_mode <= 1'b1;
    wr(orwdt_pkg::ADDR_CSR, 32'h00000054);
    wr(orwdt_pkg::ADDR_CNT, 32'h00000010);
    idle(100);
    rdc(orwdt_pkg::ADDR_CNT, 32'h00000010);
    rdc(orwdt_pkg::ADDR_CSR, 32'h000000FE);
    power_mode.halt_mode <= 1'b0;
    power_mode.subactive_mode <= 1'b1;
    idle(100);
    xfer(1'b0, orwdt_pkg::ADDR_CNT, 32'h00000000);
    chk(rd > 32'h10, 32'h1);
    wr(orwdt_pkg::ADDR_PMODE, 32'h00000000);
    xfer(1'b0, orwdt_pkg::ADDR_CNT, 32'h00000000);
    c1 = rd;
    idle(4 * SYSD);
    rdc(orwdt_pkg::ADDR_CNT, c1);
    power_mode.subactive_mode <= 1'b0;
    $display("test sources done");
    // overflow from near the top gives the chip reset pulse
    wr(orwdt_pkg::ADDR_IRQ_MASK, 32'h00000001);
    wr(orwdt_pkg::ADDR_CNT, 32'h000000FD);
    wait_rst(1'b1);
    osc_n = 0;
    wait_rst(1'b0);
    chk(osc_n >= OSCN - 1 && osc_n <= OSCN + 1, 32'h1);
    rdc(orwdt_pkg::ADDR_CSR, 32'h000000AB);
    rdc(orwdt_pkg::ADDR_CNT, 32'h00000000);
    rdc(orwdt_pkg::ADDR_IRQ_STAT, 32'h00000001);
    chk(irq, 1'b1);
    wr(orwdt_pkg::ADDR_IRQ_STAT, 32'h00000001);
    idle(1);
    chk(irq, 1'b0);
    $display("test overflow done");
    // flag survives the watchdog reset, cleared only by guarded zero
    wr(orwdt_pkg::ADDR_CSR, 32'h00000011);
    rdc(orwdt_pkg::ADDR_CSR, 32'h000000BB);
    wr(orwdt_pkg::ADDR_CSR, 32'h00000012);
    rdc(orwdt_pkg::ADDR_CSR, 32'h000000BB);
    wr(orwdt_pkg::ADDR_CSR, 32'h00000010);
    rdc(orwdt_pkg::ADDR_CSR, 32'h000000BA);
    $display("test flag_clear done");
    // unmapped address answers with an error and zero data
    rdc(8'h18, 32'h00000000);
    chk(err, 1'b1);
    $display("test unmapped done");
    print_verdict();
  end
endmodule : orwdt_top_tb

// *** verilog/orwdt_pkg.sv ***
// package: register map, field positions, counts and carriers of the watchdog
// Functional notes
// - guard bits read one, writes dropped
// - enable bits change only with guard zero
// - counter writes need counter write enable
// - run and flag writable only when enabled
// - run set or cleared by guarded write
// - counter advances only while run is set
// - overflow reset sets the overflow flag
// - flag cleared by pin reset or write
// - 8-bit counter ticks at sys/8192 or sub/32
// - rollover from max raises chip reset
// - reset follows one reference clock cycle later
// - chip reset lasts 512 oscillator cycles
// - written counter value sets overflow period
// - module stop bit zero means standby
// - stop bit stored, standby waits for run clear
// - source select picks sys/8192 or sub/32
// - counter resets to zero
// - counter halts in low power modes; here it keeps counting in subactive mode with the sub source
package orwdt_pkg;
  localparam logic [7:0] ADDR_CSR = 8'h00;
  localparam logic [7:0] ADDR_CNT = 8'h04;
  localparam logic [7:0] ADDR_STOP = 8'h08;
  localparam logic [7:0] ADDR_PMODE = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  // control/status field positions
  localparam int CNT_GUARD_BIT = 7;
  localparam int CNT_WEN_BIT = 6;
  localparam int CTRL_GUARD_BIT = 5;
  localparam int CTRL_WEN_BIT = 4;
  localparam int RUN_GUARD_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam int FLAG_GUARD_BIT = 1;
  localparam int FLAG_BIT = 0;
  localparam int STOP_BIT = 2;
  localparam int SRC_SEL_BIT = 5;
  // reset values
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic STOP_RESET = 1'b1;
  localparam logic SRC_RESET = 1'b0;
  // counts
  localparam int SYS_DIV = 8192;
  localparam int SUB_DIV = 32;
  localparam int RESET_OSC_CYCLES = 512;
  // interrupt status bits
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_REFUSED_BIT = 1;
  localparam int IRQ_WIDTH = 2;
  typedef struct packed {
    logic counter_write_enable;
    logic ctrl_write_enable;
    logic watchdog_run;
    logic overflow_reset_flag;
  } orwdt_csr_t;
  typedef struct packed {
    logic halt_mode;
    logic subactive_mode;
  } orwdt_mode_t;
endpackage : orwdt_pkg

// *** verilog/orwdt_top.sv ***
// module: overflow reset watchdog with apb register slave
//
// Added by the designer: register access over APB and the register offsets.
module orwdt_top #(
  parameter int SYS_DIV = orwdt_pkg::SYS_DIV,
  parameter int SUB_DIV = orwdt_pkg::SUB_DIV,
  parameter int RESET_OSC_CYCLES = orwdt_pkg::RESET_OSC_CYCLES
) (
  // system clock and pin reset
  input wire logic clock,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // foreign clocks, sampled as plain inputs
  input wire logic subclock,
  input wire logic osc_clock,
  // power mode from the system controller
  input wire orwdt_pkg::orwdt_mode_t power_mode,
  // outputs
  output logic wdt_chip_reset,
  output logic irq
);
  orwdt_pkg::orwdt_csr_t csr_reg;
  logic [7:0] cnt_reg;
  logic stop_reg;
  logic src_reg;
  logic [orwdt_pkg::IRQ_WIDTH-1:0] irq_stat_reg;
  logic [orwdt_pkg::IRQ_WIDTH-1:0] irq_mask_reg;
  logic [12:0] sys_div_reg;
  logic [4:0] sub_div_reg;
  logic [2:0] sub_sync_reg;
  logic [2:0] osc_sync_reg;
  logic pend_reg;
  logic [9:0] pulse_cnt_reg;
  logic wr;
  logic rd_setup;
  logic sub_rise;
  logic osc_rise;
  logic sys_tick;
  logic sub_tick;
  logic src_tick;
  logic standby;
  logic counting;
  logic count_tick;
  logic ref_edge;
  logic start_pulse;
  logic cnt_write_ok;
  logic cnt_refused;
  logic flag_clear;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == orwdt_pkg::ADDR_CSR) || (a == orwdt_pkg::ADDR_CNT) ||
      (a == orwdt_pkg::ADDR_STOP) || (a == orwdt_pkg::ADDR_PMODE) ||
      (a == orwdt_pkg::ADDR_IRQ_STAT) || (a == orwdt_pkg::ADDR_IRQ_MASK);
  endfunction : mapped

  // write commits in the access phase, answer always in its first cycle
  assign wr = psel && penable && pwrite && mapped(paddr);
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped(paddr);

  // two flops before any edge detection, third flop only for the edge
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sub_sync_reg <= 3'h0;
      osc_sync_reg <= 3'h0;
    end else begin
      sub_sync_reg <= {sub_sync_reg[1:0], subclock};
      osc_sync_reg <= {osc_sync_reg[1:0], osc_clock};
    end
  end
  assign sub_rise = sub_sync_reg[1] && !sub_sync_reg[2];
  assign osc_rise = osc_sync_reg[1] && !osc_sync_reg[2];

  // prescalers run free; phase is irrelevant to a watchdog period
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sys_div_reg <= 13'h0000;
      sub_div_reg <= 5'h00;
    end else begin
      sys_div_reg <= (sys_div_reg == 13'(SYS_DIV - 1)) ? 13'h0000 :
        sys_div_reg + 13'h0001;
      if (sub_rise) begin
        sub_div_reg <= (sub_div_reg == 5'(SUB_DIV - 1)) ? 5'h00 :
          sub_div_reg + 5'h01;
      end
    end
  end
  assign sys_tick = (sys_div_reg == 13'(SYS_DIV - 1));
  assign sub_tick = sub_rise && (sub_div_reg == 5'(SUB_DIV - 1));
  assign src_tick = src_reg ? sub_tick : sys_tick;

  // standby only takes effect once run is clear
  assign standby = !stop_reg && !csr_reg.watchdog_run;
  assign counting = csr_reg.watchdog_run && !standby &&
    !power_mode.halt_mode &&
    !(power_mode.subactive_mode && !src_reg);
  assign count_tick = counting && src_tick && !wdt_chip_reset;

  // reference clock: system clock for sys source, subclock edge otherwise
  assign ref_edge = src_reg ? sub_rise : 1'b1;
  assign start_pulse = pend_reg && ref_edge;

  // counter write permission and its refusal event
  assign cnt_write_ok = wr && (paddr == orwdt_pkg::ADDR_CNT) &&
    csr_reg.counter_write_enable;
  assign cnt_refused = wr && (paddr == orwdt_pkg::ADDR_CNT) &&
    !csr_reg.counter_write_enable;

  // watchdog counter
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_reg <= orwdt_pkg::CNT_RESET;
    end else if (start_pulse) begin
      cnt_reg <= orwdt_pkg::CNT_RESET;
    end else if (cnt_write_ok) begin
      cnt_reg <= pwdata[7:0];
    end else if (count_tick) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // overflow waits one reference cycle before the chip reset
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pend_reg <= 1'b0;
    end else if (count_tick && cnt_reg == orwdt_pkg::CNT_MAX &&
        !cnt_write_ok) begin
      pend_reg <= 1'b1;
    end else if (ref_edge) begin
      pend_reg <= 1'b0;
    end
  end

  // chip reset pulse counted in oscillator rising edges
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wdt_chip_reset <= 1'b0;
      pulse_cnt_reg <= 10'h000;
    end else if (start_pulse) begin
      wdt_chip_reset <= 1'b1;
      pulse_cnt_reg <= 10'h000;
    end else if (wdt_chip_reset && osc_rise) begin
      if (pulse_cnt_reg == 10'(RESET_OSC_CYCLES - 1)) begin
        wdt_chip_reset <= 1'b0;
      end
      pulse_cnt_reg <= pulse_cnt_reg + 10'h001;
    end
  end

  // software clear of the overflow flag
  assign flag_clear = wr && (paddr == orwdt_pkg::ADDR_CSR) &&
    csr_reg.ctrl_write_enable && !pwdata[orwdt_pkg::FLAG_GUARD_BIT] &&
    !pwdata[orwdt_pkg::FLAG_BIT];

  // control/status; guard bits are not stored at all
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      csr_reg <= '0;
    end else begin
      if (start_pulse) begin
        // the chip reset clears control but does not clear the flag, which it sets below
        csr_reg.counter_write_enable <= 1'b0;
        csr_reg.ctrl_write_enable <= 1'b0;
        csr_reg.watchdog_run <= 1'b0;
      end else if (wr && paddr == orwdt_pkg::ADDR_CSR) begin
        if (!pwdata[orwdt_pkg::CNT_GUARD_BIT]) begin
          csr_reg.counter_write_enable <=
            pwdata[orwdt_pkg::CNT_WEN_BIT];
        end
        if (!pwdata[orwdt_pkg::CTRL_GUARD_BIT]) begin
          csr_reg.ctrl_write_enable <=
            pwdata[orwdt_pkg::CTRL_WEN_BIT];
        end
        if (csr_reg.ctrl_write_enable &&
            !pwdata[orwdt_pkg::RUN_GUARD_BIT]) begin
          csr_reg.watchdog_run <= pwdata[orwdt_pkg::RUN_BIT];
        end
      end
      // set wins over clear; writing one never sets it
      if (start_pulse) begin
        csr_reg.overflow_reset_flag <= 1'b1;
      end else if (flag_clear) begin
        csr_reg.overflow_reset_flag <= 1'b0;
      end
    end
  end

  // module stop and source select, shared system bits
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stop_reg <= orwdt_pkg::STOP_RESET;
      src_reg <= orwdt_pkg::SRC_RESET;
    end else begin
      if (wr && paddr == orwdt_pkg::ADDR_STOP) begin
        stop_reg <= pwdata[orwdt_pkg::STOP_BIT];
      end
      if (wr && paddr == orwdt_pkg::ADDR_PMODE) begin
        src_reg <= pwdata[orwdt_pkg::SRC_SEL_BIT];
      end
    end
  end

  // sticky interrupt status, write one to clear, events win
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      for (int i = 0; i < orwdt_pkg::IRQ_WIDTH; i++) begin
        if (wr && paddr == orwdt_pkg::ADDR_IRQ_STAT && pwdata[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
      if (start_pulse) begin
        irq_stat_reg[orwdt_pkg::IRQ_OVF_BIT] <= 1'b1;
      end
      if (cnt_refused) begin
        irq_stat_reg[orwdt_pkg::IRQ_REFUSED_BIT] <= 1'b1;
      end
      if (wr && paddr == orwdt_pkg::ADDR_IRQ_MASK) begin
        irq_mask_reg <= pwdata[orwdt_pkg::IRQ_WIDTH-1:0];
      end
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // read data captured in the setup phase
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr)
        orwdt_pkg::ADDR_CSR: prdata <= {24'h000000, 1'b1,
          csr_reg.counter_write_enable, 1'b1, csr_reg.ctrl_write_enable,
          1'b1, csr_reg.watchdog_run, 1'b1,
          csr_reg.overflow_reset_flag};
        orwdt_pkg::ADDR_CNT: prdata <= {24'h000000, cnt_reg};
        orwdt_pkg::ADDR_STOP: prdata <= {24'h000000, 5'h1F, stop_reg, 2'h3};
        orwdt_pkg::ADDR_PMODE: prdata <= {24'h000000, 2'h0, src_reg, 5'h00};
        orwdt_pkg::ADDR_IRQ_STAT: prdata <= 32'(irq_stat_reg);
        orwdt_pkg::ADDR_IRQ_MASK: prdata <= 32'(irq_mask_reg);
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  property p_guard_read;
    @(posedge clock) disable iff (reset)
    (rd_setup && paddr == orwdt_pkg::ADDR_CSR) |=>
      (prdata[7:0] & 8'hAA) == 8'hAA;
  endproperty
  a_guard_read: assert property (p_guard_read)
    else $error("guard bit read as zero");

  property p_cwe_guarded;
    @(posedge clock) disable iff (reset)
    (wr && paddr == orwdt_pkg::ADDR_CSR && pwdata[7] && !start_pulse) |=>
      $stable(csr_reg.counter_write_enable);
  endproperty
  a_cwe_guarded: assert property (p_cwe_guarded)
    else $error("counter write enable changed with guard set");

  property p_cnt_refused;
    @(posedge clock) disable iff (reset)
    (cnt_refused && !count_tick && !start_pulse) |=> $stable(cnt_reg);
  endproperty
  a_cnt_refused: assert property (p_cnt_refused)
    else $error("counter written while writes disabled");

  property p_run_needs_enable;
    @(posedge clock) disable iff (reset)
    $rose(csr_reg.watchdog_run) |->
      $past(csr_reg.ctrl_write_enable) && !$past(pwdata[3]);
  endproperty
  a_run_needs_enable: assert property (p_run_needs_enable)
    else $error("run set without control write enable");

  property p_count_needs_run;
    @(posedge clock) disable iff (reset)
    (!csr_reg.watchdog_run && !cnt_write_ok && !start_pulse) |=>
      $stable(cnt_reg);
  endproperty
  a_count_needs_run: assert property (p_count_needs_run)
    else $error("counter moved while stopped");

  property p_flag_on_pulse;
    @(posedge clock) disable iff (reset)
    start_pulse |=> csr_reg.overflow_reset_flag && wdt_chip_reset;
  endproperty
  a_flag_on_pulse: assert property (p_flag_on_pulse)
    else $error("overflow flag not set with chip reset");

  property p_flag_clear_cause;
    @(posedge clock) disable iff (reset)
    $fell(csr_reg.overflow_reset_flag) |-> $past(flag_clear);
  endproperty
  a_flag_clear_cause: assert property (p_flag_clear_cause)
    else $error("overflow flag cleared without software write");

  property p_sys_ref_delay;
    @(posedge clock) disable iff (reset)
    (count_tick && cnt_reg == 8'hFF && !cnt_write_ok && !src_reg) |=>
      ##1 $rose(wdt_chip_reset);
  endproperty
  a_sys_ref_delay: assert property (p_sys_ref_delay)
    else $error("chip reset not one system cycle after overflow");

  property p_pulse_hold;
    @(posedge clock) disable iff (reset)
    (wdt_chip_reset &&
      !(osc_rise && pulse_cnt_reg == 10'(RESET_OSC_CYCLES - 1))) |=>
      wdt_chip_reset;
  endproperty
  a_pulse_hold: assert property (p_pulse_hold)
    else $error("chip reset ended early");

  property p_pulse_end;
    @(posedge clock) disable iff (reset)
    (wdt_chip_reset && osc_rise &&
      pulse_cnt_reg == 10'(RESET_OSC_CYCLES - 1) && !start_pulse) |=>
      !wdt_chip_reset;
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("chip reset outlasted its oscillator count");

  property p_standby_halts;
    @(posedge clock) disable iff (reset)
    ((standby || power_mode.halt_mode) && !cnt_write_ok && !start_pulse)
      |=> $stable(cnt_reg);
  endproperty
  a_standby_halts: assert property (p_standby_halts)
    else $error("counter ticked in standby or halt mode");
endmodule : orwdt_top
